// [design/ext_irq_consts.svh]
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

// ==========================================================
// register map, byte addresses
`define OFS_EVENT_CONTROL 8'h04
`define OFS_ENABLE_CLEAR 8'h08
`define OFS_ENABLE_SET 8'h0c
`define OFS_IRQ_FLAGS 8'h10
`define OFS_WAKE_ENABLES 8'h14
`define OFS_SENSE_CONFIG 8'h18

// ==========================================================
// reset values
`define RST_LINE_BITS 8'h00
`define RST_CONFIG 32'h00000000

// ==========================================================
// field layout
`define NUM_LINES 8
`define NIBBLE_W 4
`define SENSE_LSB 0
`define SENSE_MSB 2
`define FILTER_BIT 3
`define LINE_MSB 7

`endif

// [design/ext_irq_pkg.sv]
package ext_irq_pkg;

    // ==========================================================
    // input sense codes; 3'b110 and 3'b111 are reserved
    typedef enum logic [2:0] {
        SENSE_OFF = 3'b000,
        SENSE_RISE = 3'b001,
        SENSE_FALL = 3'b010,
        SENSE_BOTH = 3'b011,
        SENSE_HIGH = 3'b100,
        SENSE_LOW = 3'b101
    } sense_t;

endpackage

// [design/ext_line_detect.sv]
`timescale 1ns/1ps
`include "ext_irq_consts.svh"

module ext_line_detect
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised pin level
    input wire logic sample,
    // line configuration
    input wire logic filt_en,
    input wire logic [2:0] sense,
    // detection, level
    output logic hit
);

    // ==========================================================
    // helpers
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    logic [1:0] hist_q;
    logic prev_q;
    logic voted;
    logic chosen;
    logic rise;
    logic fall;

    // three-sample vote rejects a single-cycle glitch at the cost of one cycle latency
    assign voted = maj3(sample, hist_q[0], hist_q[1]);
    assign chosen = filt_en ? voted : sample;
    assign rise = chosen & ~prev_q;
    assign fall = ~chosen & prev_q;

    // sense decode; reserved codes detect nothing
    always_comb begin
        case (sense)
            SENSE_RISE: hit = rise;
            SENSE_FALL: hit = fall;
            SENSE_BOTH: hit = rise | fall;
            SENSE_HIGH: hit = chosen;
            SENSE_LOW: hit = ~chosen;
            default: hit = 1'b0;
        endcase
    end

    // sample history
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hist_q <= 2'b00;
            prev_q <= 1'b0;
        end else begin
            hist_q <= {hist_q[0], sample};
            prev_q <= chosen;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SENSE_OFF: assert property (sense == SENSE_OFF |-> !hit)
        else $error("hit with detection off");
    AST_RISE_UNFILT: assert property (
        (sense == SENSE_RISE && !filt_en && !$past(filt_en) && sample && !$past(sample)) |-> hit)
        else $error("rising edge missed");
    AST_LOW_LEVEL: assert property ((sense == SENSE_LOW && !filt_en && !sample) |-> hit)
        else $error("low level missed");
    AST_FILTER_GLITCH: assert property (
        (filt_en && sense == SENSE_HIGH && !hist_q[0] && !hist_q[1]) |-> !hit)
        else $error("filter passed a single sample");

endmodule // ext_line_detect

// [design/ext_irq_ctrl.sv]
`timescale 1ns/1ps
`include "ext_irq_consts.svh"

module ext_irq_ctrl
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // external pins
    input wire logic [7:0] EXT_IRQ_LINE,
    // system outputs
    output logic IRQ,
    output logic [7:0] EVENT_OUT,
    output logic WAKE_REQ
);

    // ==========================================================
    // state
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [7:0] wake_en_q;
    logic [7:0] evt_en_q;
    logic [31:0] cfg_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] event_q;
    logic wake_q;
    logic [7:0] hit;
    logic [7:0] wake_en_d;
    logic [7:0] evt_en_d;
    logic [31:0] cfg_d;
    logic [7:0] event_d;
    logic wake_d;

    // ==========================================================
    // helpers

    // one compare per register; offsets outside the map select nothing
    function automatic logic at_ofs(input logic [7:0] addr, input logic [7:0] ofs);
        at_ofs = (addr == ofs);
    endfunction

    // write-one-to-clear, shared by the enable and the flag paths
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] mask);
        w1c = cur & ~mask;
    endfunction

    // ==========================================================
    // bus decode
    wire setup_rd = PSEL & ~PENABLE & ~PWRITE;
    wire wr_acc = PSEL & PENABLE & PWRITE;
    wire sel_evt = at_ofs(PADDR, `OFS_EVENT_CONTROL);
    wire sel_clr = at_ofs(PADDR, `OFS_ENABLE_CLEAR);
    wire sel_set = at_ofs(PADDR, `OFS_ENABLE_SET);
    wire sel_flag = at_ofs(PADDR, `OFS_IRQ_FLAGS);
    wire sel_wake = at_ofs(PADDR, `OFS_WAKE_ENABLES);
    wire sel_cfg = at_ofs(PADDR, `OFS_SENSE_CONFIG);
    wire mapped = sel_evt | sel_clr | sel_set | sel_flag | sel_wake | sel_cfg;
    wire [7:0] wbits = PWDATA[`LINE_MSB:0];

    // zero-wait slave; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign PRDATA = rdata_q;

    // read mux, upper bits zero except for the sense config register, which returns all 32 bits
    always_comb begin
        rdata_d = 32'h00000000;
        if (sel_evt) begin
            rdata_d[7:0] = evt_en_q;
        end
        if (sel_clr | sel_set) begin
            rdata_d[7:0] = enable_q;
        end
        if (sel_flag) begin
            rdata_d[7:0] = flag_q;
        end
        if (sel_wake) begin
            rdata_d[7:0] = wake_en_q;
        end
        if (sel_cfg) begin
            rdata_d = cfg_q;
        end
    end

    // enable: set and clear views act on one register
    assign enable_d = (wr_acc & sel_set) ? (enable_q | wbits) :
        (wr_acc & sel_clr) ? w1c(enable_q, wbits) : enable_q;
    // a detection in the clearing cycle survives the clear
    assign flag_d = ((wr_acc & sel_flag) ? w1c(flag_q, wbits) : flag_q) | hit;

    // plain read-write registers change only on a write access
    assign wake_en_d = (wr_acc & sel_wake) ? wbits : wake_en_q;
    assign evt_en_d = (wr_acc & sel_evt) ? wbits : evt_en_q;
    // all 32 bits are configuration, so nothing is masked here
    assign cfg_d = (wr_acc & sel_cfg) ? PWDATA : cfg_q;

    // outputs follow the detections one cycle later
    assign event_d = hit & evt_en_q;
    assign wake_d = |(hit & wake_en_q);

    // ==========================================================
    // pin synchroniser; first stage feeds only the second
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= EXT_IRQ_LINE;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // per-line detectors, nibble x configures line x
    for (genvar i = 0; i < `NUM_LINES; i++) begin : g_line
        ext_line_detect u_det (
            .clk(CLK_SYS),
            .rst_n(RST_N),
            .sample(sync2_q[i]),
            .filt_en(cfg_q[i*`NIBBLE_W + `FILTER_BIT]),
            .sense(cfg_q[i*`NIBBLE_W + `SENSE_MSB -: 3]),
            .hit(hit[i])
        );
    end

    // ==========================================================
    // registers, one short process each

    // interrupt enables; one register behind both views
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            enable_q <= `RST_LINE_BITS;
        end else begin
            enable_q <= enable_d;
        end
    end

    // interrupt flags
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            flag_q <= `RST_LINE_BITS;
        end else begin
            flag_q <= flag_d;
        end
    end

    // wake-up enables
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wake_en_q <= `RST_LINE_BITS;
        end else begin
            wake_en_q <= wake_en_d;
        end
    end

    // event output enables
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            evt_en_q <= `RST_LINE_BITS;
        end else begin
            evt_en_q <= evt_en_d;
        end
    end

    // sense and filter configuration
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cfg_q <= `RST_CONFIG;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // read data snapshot at the setup edge, held until the next read setup
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rdata_q <= 32'h00000000;
        end else if (setup_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // event and wake outputs, registered to keep them glitch free; IRQ is an unregistered OR of flags ANDed with enables
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            event_q <= 8'h00;
            wake_q <= 1'b0;
        end else begin
            event_q <= event_d;
            wake_q <= wake_d;
        end
    end

    assign EVENT_OUT = event_q;
    assign WAKE_REQ = wake_q;
    assign IRQ = |(flag_q & enable_q);

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    AST_RSVD_ZERO: assert property (
        (PSEL && PENABLE && !PWRITE && !sel_cfg) |-> PRDATA[31:8] == 24'h000000)
        else $error("reserved read bits not zero");
    AST_ENABLE_SET: assert property ((wr_acc && sel_set) |=>
        enable_q == ($past(enable_q) | $past(wbits)))
        else $error("enable set wrong");
    AST_ENABLE_CLR: assert property ((wr_acc && sel_clr) |=>
        enable_q == ($past(enable_q) & ~$past(wbits)))
        else $error("enable clear wrong");
    AST_FLAG_SET: assert property ((|hit) |=> ((flag_q & $past(hit)) == $past(hit)))
        else $error("detection did not set flag");
    AST_IRQ_CAUSE: assert property (IRQ |-> |(flag_q & enable_q))
        else $error("irq without enabled flag");
    AST_FLAG_W1C: assert property ((wr_acc && sel_flag && hit == 8'h00) |=>
        flag_q == ($past(flag_q) & ~$past(wbits)))
        else $error("flag clear wrong");
    AST_FLAG_HOLD: assert property ((!(wr_acc && sel_flag) && hit == 8'h00) |=>
        $stable(flag_q))
        else $error("flag changed without cause");
    AST_WAKE: assert property ((|(hit & wake_en_q)) |=> WAKE_REQ)
        else $error("wake request missed");
    AST_NO_WAKE: assert property ((hit & wake_en_q) == 8'h00 |=> !WAKE_REQ)
        else $error("spurious wake request");
    AST_EVENT: assert property (1'b1 |=> EVENT_OUT == ($past(hit) & $past(evt_en_q)))
        else $error("event output wrong");
    AST_SYNC_DELAY: assert property (##2 sync2_q == $past(EXT_IRQ_LINE, 2))
        else $error("synchroniser delay wrong");

    // read path: each read returns the state held at the setup edge
    AST_RD_ENABLE: assert property ((setup_rd && (sel_set || sel_clr)) |=>
        PRDATA == {24'h000000, $past(enable_q)})
        else $error("enable read wrong");
    AST_RD_FLAGS: assert property ((setup_rd && sel_flag) |=>
        PRDATA == {24'h000000, $past(flag_q)})
        else $error("flag read wrong");
    AST_RD_WAKE: assert property ((setup_rd && sel_wake) |=>
        PRDATA == {24'h000000, $past(wake_en_q)})
        else $error("wake enable read wrong");
    AST_RD_EVT: assert property ((setup_rd && sel_evt) |=>
        PRDATA == {24'h000000, $past(evt_en_q)})
        else $error("event enable read wrong");
    AST_RD_CFG: assert property ((setup_rd && sel_cfg) |=> PRDATA == $past(cfg_q))
        else $error("config read wrong");
    AST_RD_UNMAPPED: assert property ((setup_rd && !mapped) |=> PRDATA == 32'h00000000)
        else $error("unmapped read not zero");

    // write path: plain registers take the written bits, enables move only on writes
    AST_WAKE_WRITE: assert property ((wr_acc && sel_wake) |=> wake_en_q == $past(wbits))
        else $error("wake enable write wrong");
    AST_EVT_WRITE: assert property ((wr_acc && sel_evt) |=> evt_en_q == $past(wbits))
        else $error("event enable write wrong");
    AST_CFG_WRITE: assert property ((wr_acc && sel_cfg) |=> cfg_q == $past(PWDATA))
        else $error("config write wrong");
    AST_ENABLE_HOLD: assert property (!(wr_acc && (sel_set || sel_clr)) |=>
        $stable(enable_q))
        else $error("enable changed without write");

    // pin side and system outputs
    AST_SYNC_FIRST: assert property (1'b1 |=> sync1_q == $past(EXT_IRQ_LINE))
        else $error("first synchroniser stage wrong");
    AST_IRQ_ENABLED: assert property ((|(flag_q & enable_q)) |-> IRQ)
        else $error("enabled flag without irq");
    AST_IRQ_NO_EN: assert property ((enable_q == 8'h00) |-> !IRQ)
        else $error("irq with all enables off");
    AST_EVT_MASKED: assert property ((evt_en_q == 8'h00) |=> EVENT_OUT == 8'h00)
        else $error("event with all outputs disabled");
    AST_WAKE_MASKED: assert property ((wake_en_q == 8'h00) |=> !WAKE_REQ)
        else $error("wake with all wake enables off");

    COV_IRQ: cover property ($rose(IRQ));
    COV_CLEAR: cover property (wr_acc && sel_flag && |(flag_q & wbits));
    COV_WAKE: cover property (WAKE_REQ);
    COV_EVENT: cover property (|EVENT_OUT);
    COV_SET_WINS: cover property (wr_acc && sel_flag && |(hit & wbits));

endmodule // ext_irq_ctrl

// [test/ext_pin_model.sv]
`timescale 1ns/1ps

// ==========================================
// external pin driver
module ext_pin_model (
    // clock
    input wire logic clk,
    // pins toward the block
    output logic [7:0] pins
);
    initial pins = 8'h00;

    // pins move only just after an edge; hold 0 gives a one-cycle glitch
    task automatic set_line(input int ln, input logic v, input int hold);
        @(posedge clk);
        pins[ln] <= v;
        repeat (hold) @(posedge clk);
    endtask
endmodule // ext_pin_model

// [test/test_ext_irq_ctrl.sv]
`timescale 1ns/1ps
`include "ext_irq_consts.svh"

module test_ext_irq_ctrl;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq, wake_req, err;
    logic [7:0] paddr, pins, event_out;
    logic [31:0] pwdata, prdata, rd;
    int miscompares = 0, n_tests = 0, evt_cnt = 0, wake_cnt = 0, e0, w0;

    ext_irq_ctrl ext_irq_ctrl_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_LINE(pins),
        .IRQ(irq), .EVENT_OUT(event_out), .WAKE_REQ(wake_req));
    ext_pin_model ext_pin_model_i (.clk(clk_sys), .pins(pins));

    // ==========================================
    // clock, pulse counters, watchdog
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    // counting pulses avoids guessing the exact cycle of each one
    always @(posedge clk_sys) begin
        evt_cnt <= evt_cnt + $countones(event_out);
        wake_cnt <= wake_cnt + (wake_req === 1'b1);
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end

    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // apb: hold request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(0, a, 0);
        chk(nm, rd, exp);
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        for (int a = 4; a <= 24; a += 4) rdchk(a[7:0], 0, "reset value");
        apb(0, 8'h1c, 0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
    endtask
    task automatic t_enable();
        apb(1, `OFS_ENABLE_SET, 32'h0f);
        rdchk(`OFS_ENABLE_SET, 32'h0f, "enable set");
        apb(1, `OFS_ENABLE_SET, 32'h30);
        rdchk(`OFS_ENABLE_SET, 32'h3f, "enable keep");
        apb(1, `OFS_ENABLE_CLEAR, 32'h03);
        rdchk(`OFS_ENABLE_CLEAR, 32'h3c, "enable clear");
        rdchk(`OFS_ENABLE_SET, 32'h3c, "enable view");
        apb(1, `OFS_ENABLE_CLEAR, 32'hff);
    endtask
    task automatic t_rise();
        apb(1, `OFS_SENSE_CONFIG, 32'h1);
        apb(1, `OFS_EVENT_CONTROL, 32'h1);
        apb(1, `OFS_WAKE_ENABLES, 32'h1);
        apb(1, `OFS_ENABLE_SET, 32'h1);
        e0 = evt_cnt;
        w0 = wake_cnt;
        ext_pin_model_i.set_line(0, 1, 6);
        rdchk(`OFS_IRQ_FLAGS, 32'h1, "rise flag");
        chk("irq on", irq, 1);
        chk("rise events", evt_cnt - e0, 1);
        chk("rise wake", wake_cnt - w0, 1);
        apb(1, `OFS_IRQ_FLAGS, 32'hfe);
        rdchk(`OFS_IRQ_FLAGS, 32'h1, "zero write");
        apb(1, `OFS_IRQ_FLAGS, 32'h1);
        rdchk(`OFS_IRQ_FLAGS, 32'h0, "flag cleared");
        chk("irq off", irq, 0);
        ext_pin_model_i.set_line(0, 0, 2);
    endtask
    // every sense code on line 1, masked, no wake
    task automatic t_sense();
        logic [7:0] f1 = 8'h3a, f2 = 8'h3c;
        int ev[8] = '{0, 1, 1, 2, 0, 0, 0, 0};
        apb(1, `OFS_WAKE_ENABLES, 0);
        apb(1, `OFS_EVENT_CONTROL, 32'h2);
        for (int c = 0; c < 8; c++) begin
            apb(1, `OFS_SENSE_CONFIG, {24'h0, 1'b0, c[2:0], 4'h0});
            repeat (6) @(posedge clk_sys);
            apb(1, `OFS_IRQ_FLAGS, 32'hff);
            e0 = evt_cnt;
            w0 = wake_cnt;
            ext_pin_model_i.set_line(1, 1, 6);
            rdchk(`OFS_IRQ_FLAGS, {30'h0, f1[c], 1'b0}, "sense high phase");
            chk("irq masked", irq, 0);
            apb(1, `OFS_IRQ_FLAGS, 32'hff);
            ext_pin_model_i.set_line(1, 0, 6);
            rdchk(`OFS_IRQ_FLAGS, {30'h0, f2[c], 1'b0}, "sense low phase");
            if (c == 4 || c == 5) chk("level events", (evt_cnt - e0) > 2, 1);
            else chk("edge events", evt_cnt - e0, ev[c]);
            chk("no wake", wake_cnt - w0, 0);
        end
    endtask
    // line 2: glitch refused with filter, seen without
    task automatic t_filter();
        apb(1, `OFS_EVENT_CONTROL, 32'h1);
        apb(1, `OFS_SENSE_CONFIG, 32'h900);
        apb(1, `OFS_IRQ_FLAGS, 32'hff);
        e0 = evt_cnt;
        ext_pin_model_i.set_line(2, 1, 0);
        ext_pin_model_i.set_line(2, 0, 6);
        rdchk(`OFS_IRQ_FLAGS, 0, "glitch filtered");
        ext_pin_model_i.set_line(2, 1, 6);
        rdchk(`OFS_IRQ_FLAGS, 32'h4, "filtered rise");
        chk("event gated", evt_cnt - e0, 0);
        apb(1, `OFS_SENSE_CONFIG, 32'h100);
        ext_pin_model_i.set_line(2, 0, 6);
        apb(1, `OFS_IRQ_FLAGS, 32'hff);
        ext_pin_model_i.set_line(2, 1, 0);
        ext_pin_model_i.set_line(2, 0, 6);
        rdchk(`OFS_IRQ_FLAGS, 32'h4, "glitch unfiltered");
    endtask

    // ==========================================
    // main sequence
    initial begin
        rst_n = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        t_reset();
        t_enable();
        t_rise();
        t_sense();
        t_filter();
        close_out();
    end
endmodule // test_ext_irq_ctrl
